// ### design/dspt_regs.svh
/*
  Constants for the dual-slope 16-bit PWM timer: mode codes, fixed TOP
  values, prescaler divisors and reset values.
  Assumes it is included by bare name ahead of the package and the design.
*/
`ifndef DSPT_REGS_SVH
`define DSPT_REGS_SVH

// ----------------------------------------------------------------------
// Waveform select codes
// ----------------------------------------------------------------------
`define DSPT_WS_PC_8      4'h1
`define DSPT_WS_PC_9      4'h2
`define DSPT_WS_PC_10     4'h3
`define DSPT_WS_PFC_CAP   4'h8
`define DSPT_WS_PFC_CMPA  4'h9
`define DSPT_WS_PC_CAP    4'ha
`define DSPT_WS_PC_CMPA   4'hb

// ----------------------------------------------------------------------
// TOP values
// ----------------------------------------------------------------------
`define DSPT_TOP_8        16'h00ff
`define DSPT_TOP_9        16'h01ff
`define DSPT_TOP_10       16'h03ff
`define DSPT_TOP_MAX      16'hffff
`define DSPT_BOTTOM       16'h0000

// ----------------------------------------------------------------------
// Output action codes
// ----------------------------------------------------------------------
`define DSPT_ACT_OFF      2'h0
`define DSPT_ACT_TOGGLE   2'h1
`define DSPT_ACT_NONINV   2'h2
`define DSPT_ACT_INV      2'h3

// ----------------------------------------------------------------------
// Prescaler select codes and divisors
// ----------------------------------------------------------------------
`define DSPT_PS_STOP      3'h0
`define DSPT_PS_DIV1      3'h1
`define DSPT_PS_DIV8      3'h2
`define DSPT_PS_DIV64     3'h3
`define DSPT_PS_DIV256    3'h4
`define DSPT_PS_DIV1024   3'h5
`define DSPT_DIV_1        10'h000
`define DSPT_DIV_8        10'h007
`define DSPT_DIV_64       10'h03f
`define DSPT_DIV_256      10'h0ff
`define DSPT_DIV_1024     10'h3ff

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DSPT_RST_VALUE    16'h0000
`define DSPT_RST_PRESC    10'h000

`endif

// ### design/dspt_pkg.sv
/*
  Types shared by the dual-slope PWM timer.
  Assumes dspt_regs.svh is compiled alongside.
*/
package dspt_pkg;

  // ----------------------------------------------------------------------
  // Flag vector, also used for the clear strobes
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic overflow_flag;
    logic capture_flag;
    logic compare_match_flag_a;
    logic compare_match_flag_b;
  } dspt_flags_t;

  // ----------------------------------------------------------------------
  // Count direction
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    DSPT_UP   = 2'b01,
    DSPT_DOWN = 2'b10
  } dspt_dir_t;

endpackage : dspt_pkg

// ### design/dspt_timer.sv
/*
  Dual-slope 16-bit PWM timer: phase correct and phase-and-frequency
  correct modes, double-buffered compares, flags and two compare outputs.
  Assumes all inputs are synchronous to clk_sys; software sets TOP at or
  above every compare value and at least 0x0003 when a register holds it.
*/
`include "dspt_regs.svh"

module dspt_timer
  import dspt_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Configuration
  input  wire logic [3:0]  waveform_select,
  input  wire logic [2:0]  prescale_select,
  input  wire logic [1:0]  output_action_a,
  input  wire logic [1:0]  output_action_b,
  input  wire logic        pin_direction_bit_a,
  input  wire logic        pin_direction_bit_b,
  input  wire logic        port_data_a,
  input  wire logic        port_data_b,
  // Register writes
  input  wire logic        compare_a_wr,
  input  wire logic        compare_b_wr,
  input  wire logic        capture_top_wr,
  input  wire logic [15:0] wr_data,
  // Flag clears, one bit per flag
  input  wire dspt_flags_t flag_clear,
  // Status
  output logic      [15:0] counter_value,
  output logic      [15:0] compare_a_value,
  output logic      [15:0] compare_b_value,
  output logic      [15:0] capture_top_value,
  output dspt_flags_t      flags,
  output logic             compare_out_a,
  output logic             compare_out_b,
  // Pins
  output logic             pin_a_out,
  output logic             pin_a_oe_n,
  output logic             pin_b_out,
  output logic             pin_b_oe_n
);

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  logic        mode_pc;
  logic        mode_pfc;
  logic        top_from_cap;
  logic        top_from_cmpa;
  logic        top_fixed;
  logic [15:0] top_value;
  logic [15:0] buf_a;
  logic [15:0] buf_b;

  always_comb begin
    mode_pc       = 1'b0;
    mode_pfc      = 1'b0;
    top_from_cap  = 1'b0;
    top_from_cmpa = 1'b0;
    top_fixed     = 1'b0;
    top_value     = `DSPT_TOP_MAX;
    case (waveform_select)
      `DSPT_WS_PC_8: begin
        mode_pc   = 1'b1;
        top_fixed = 1'b1;
        top_value = `DSPT_TOP_8;
      end
      `DSPT_WS_PC_9: begin
        mode_pc   = 1'b1;
        top_fixed = 1'b1;
        top_value = `DSPT_TOP_9;
      end
      `DSPT_WS_PC_10: begin
        mode_pc   = 1'b1;
        top_fixed = 1'b1;
        top_value = `DSPT_TOP_10;
      end
      `DSPT_WS_PC_CAP: begin
        mode_pc      = 1'b1;
        top_from_cap = 1'b1;
        top_value    = capture_top_value;
      end
      `DSPT_WS_PC_CMPA: begin
        mode_pc       = 1'b1;
        top_from_cmpa = 1'b1;
        top_value     = compare_a_value;
      end
      `DSPT_WS_PFC_CAP: begin
        mode_pfc     = 1'b1;
        top_from_cap = 1'b1;
        top_value    = capture_top_value;
      end
      `DSPT_WS_PFC_CMPA: begin
        mode_pfc      = 1'b1;
        top_from_cmpa = 1'b1;
        top_value     = compare_a_value;
      end
      default: begin
        top_value = `DSPT_TOP_MAX;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------
  logic [9:0] presc_cnt;
  logic [9:0] next_presc_cnt;
  logic [9:0] presc_last;
  logic       presc_run;
  logic       timer_tick;

  always_comb begin
    presc_run  = 1'b1;
    presc_last = `DSPT_DIV_1;
    case (prescale_select)
      `DSPT_PS_DIV1:    presc_last = `DSPT_DIV_1;
      `DSPT_PS_DIV8:    presc_last = `DSPT_DIV_8;
      `DSPT_PS_DIV64:   presc_last = `DSPT_DIV_64;
      `DSPT_PS_DIV256:  presc_last = `DSPT_DIV_256;
      `DSPT_PS_DIV1024: presc_last = `DSPT_DIV_1024;
      default:          presc_run  = 1'b0;
    endcase
    // Stopping resets the phase so a restart gives a full first period
    timer_tick     = presc_run && (presc_cnt >= presc_last);
    next_presc_cnt = `DSPT_RST_PRESC;
    if (presc_run && !timer_tick) begin
      next_presc_cnt = presc_cnt + 10'h001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      presc_cnt <= `DSPT_RST_PRESC;
    end else begin
      presc_cnt <= next_presc_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // Counter, direction and compare registers
  // ----------------------------------------------------------------------
  dspt_dir_t   dir;
  dspt_dir_t   next_dir;
  logic [15:0] next_counter;
  logic [15:0] next_cmp_a;
  logic [15:0] next_cmp_b;
  logic [15:0] next_buf_a;
  logic [15:0] next_buf_b;
  logic [15:0] next_cap_top;
  logic [15:0] wr_masked;
  logic        dual;
  logic        at_top;
  logic        at_bottom;
  logic        update_now;

  always_comb begin
    dual      = mode_pc || mode_pfc;
    at_top    = dual && timer_tick && (counter_value == top_value);
    at_bottom = dual && timer_tick && (counter_value == `DSPT_BOTTOM);
    wr_masked = top_fixed ? (wr_data & top_value) : wr_data;
    next_counter = counter_value;
    next_dir     = dir;
    if (dual && timer_tick) begin
      if (dir == DSPT_UP) begin
        if (counter_value == top_value) begin
          next_counter = counter_value - 16'h0001;
          next_dir     = DSPT_DOWN;
        end else begin
          next_counter = counter_value + 16'h0001;
        end
      end else begin
        if (counter_value == `DSPT_BOTTOM) begin
          next_counter = counter_value + 16'h0001;
          next_dir     = DSPT_UP;
        end else begin
          next_counter = counter_value - 16'h0001;
        end
      end
    end
    next_buf_a = compare_a_wr ? wr_masked : buf_a;
    next_buf_b = compare_b_wr ? wr_masked : buf_b;
    next_cap_top = capture_top_wr ? wr_data : capture_top_value;
    // Outside dual-slope modes there is no update point, so buffers pass straight on
    update_now = !dual || (mode_pc && at_top) || (mode_pfc && at_bottom);
    next_cmp_a = update_now ? buf_a : compare_a_value;
    next_cmp_b = update_now ? buf_b : compare_b_value;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      counter_value     <= `DSPT_RST_VALUE;
      dir               <= DSPT_UP;
      buf_a             <= `DSPT_RST_VALUE;
      buf_b             <= `DSPT_RST_VALUE;
      compare_a_value   <= `DSPT_RST_VALUE;
      compare_b_value   <= `DSPT_RST_VALUE;
      capture_top_value <= `DSPT_RST_VALUE;
    end else begin
      counter_value     <= next_counter;
      dir               <= next_dir;
      buf_a             <= next_buf_a;
      buf_b             <= next_buf_b;
      compare_a_value   <= next_cmp_a;
      compare_b_value   <= next_cmp_b;
      capture_top_value <= next_cap_top;
    end
  end

  // ----------------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------------
  dspt_flags_t next_flags;
  dspt_flags_t flag_set;
  logic        match_a;
  logic        match_b;

  always_comb begin
    match_a  = dual && timer_tick && (counter_value == compare_a_value);
    match_b  = dual && timer_tick && (counter_value == compare_b_value);
    flag_set.overflow_flag        = at_bottom;
    flag_set.capture_flag         = at_top && top_from_cap;
    flag_set.compare_match_flag_a = match_a || (at_top && top_from_cmpa);
    flag_set.compare_match_flag_b = match_b;
    // A set arriving with its clear wins
    next_flags = (flags & ~flag_clear) | flag_set;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  // ----------------------------------------------------------------------
  // Compare outputs and pins
  // ----------------------------------------------------------------------
  logic next_out_a;
  logic next_out_b;
  logic next_pin_a;
  logic next_pin_b;
  logic rising;
  logic toggle_ok;
  logic conn_a;
  logic conn_b;

  // Match at BOTTOM acts as an up match, at TOP as a down match, so the
  // extreme compare values hold the output steady
  always_comb begin
    if (counter_value == `DSPT_BOTTOM) begin
      rising = 1'b1;
    end else if (counter_value == top_value) begin
      rising = 1'b0;
    end else begin
      rising = (dir == DSPT_UP);
    end
    toggle_ok  = top_from_cmpa;
    next_out_a = compare_out_a;
    next_out_b = compare_out_b;
    if (match_a) begin
      if (output_action_a == `DSPT_ACT_NONINV) begin
        next_out_a = !rising;
      end else if (output_action_a == `DSPT_ACT_INV) begin
        next_out_a = rising;
      end else if (output_action_a == `DSPT_ACT_TOGGLE && toggle_ok) begin
        next_out_a = !compare_out_a;
      end
    end
    if (match_b) begin
      if (output_action_b == `DSPT_ACT_NONINV) begin
        next_out_b = !rising;
      end else if (output_action_b == `DSPT_ACT_INV) begin
        next_out_b = rising;
      end
    end
    conn_a = (output_action_a == `DSPT_ACT_NONINV) || (output_action_a == `DSPT_ACT_INV)
             || (output_action_a == `DSPT_ACT_TOGGLE && toggle_ok);
    conn_b = (output_action_b == `DSPT_ACT_NONINV) || (output_action_b == `DSPT_ACT_INV);
    next_pin_a = conn_a ? next_out_a : port_data_a;
    next_pin_b = conn_b ? next_out_b : port_data_b;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      compare_out_a <= 1'b0;
      compare_out_b <= 1'b0;
      pin_a_out     <= 1'b0;
      pin_b_out     <= 1'b0;
      pin_a_oe_n    <= 1'b1;
      pin_b_oe_n    <= 1'b1;
    end else begin
      compare_out_a <= next_out_a;
      compare_out_b <= next_out_b;
      pin_a_out     <= next_pin_a;
      pin_b_out     <= next_pin_b;
      pin_a_oe_n    <= !pin_direction_bit_a;
      pin_b_oe_n    <= !pin_direction_bit_b;
    end
  end

endmodule : dspt_timer

// ### tb/dspt_timer_assertions.sv
/*
  Port assertions for the dual-slope timer, bound into dspt_timer.
  Assumes one clock, clk_sys, and the synchronous active-high reset.
*/
module dspt_chk
  import dspt_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // Controls
  input wire logic [3:0]  waveform_select,
  input wire logic [2:0]  prescale_select,
  input wire logic [1:0]  output_action_a,
  input wire logic        pin_direction_bit_a,
  input wire logic        port_data_a,
  input wire logic        capture_top_wr,
  input wire logic [15:0] wr_data,
  // Status and pins
  input wire logic [15:0] counter_value,
  input wire logic [15:0] compare_a_value,
  input wire logic [15:0] compare_b_value,
  input wire logic [15:0] capture_top_value,
  input wire dspt_flags_t flags,
  input wire logic        compare_out_a,
  input wire logic        pin_a_out,
  input wire logic        pin_a_oe_n
);
  logic [15:0] top_now;
  always_comb begin
    case (waveform_select)
      4'h1: top_now = 16'h00ff;
      4'h2: top_now = 16'h01ff;
      4'h3: top_now = 16'h03ff;
      4'ha: top_now = capture_top_value;
      default: top_now = compare_a_value;
    endcase
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // A tick is only visible as a counter step
  sequence s_step;
    counter_value != $past(counter_value);
  endsequence
  sequence s_leave_bottom;
    $past(counter_value) == 16'h0000 && counter_value == 16'h0001;
  endsequence
  chk_count_step: assert property (
    s_step |-> counter_value == $past(counter_value) + 16'h0001 || counter_value == $past(counter_value) - 16'h0001)
    else $error("counter moved by more than one");
  chk_ovf_bottom: assert property (s_leave_bottom |-> flags.overflow_flag)
    else $error("overflow flag missing at bottom");
  chk_match_a: assert property (
    s_step and $past(counter_value) == $past(compare_a_value) |-> flags.compare_match_flag_a)
    else $error("compare match flag a missing");
  chk_cap_direct: assert property (capture_top_wr |=> capture_top_value == $past(wr_data))
    else $error("capture-top not taken at once");
  chk_pfc_load: assert property (
    waveform_select inside {4'h8, 4'h9} && $stable(waveform_select) && $changed(compare_a_value)
    |-> $past(counter_value) == 16'h0000)
    else $error("compare a loaded away from bottom");
  chk_pc_load: assert property (
    waveform_select inside {4'h1, 4'h2, 4'h3, 4'ha, 4'hb} && $stable(waveform_select) && $changed(compare_b_value)
    |-> $past(counter_value) == $past(top_now))
    else $error("compare b loaded away from top");
  chk_toggle_a: assert property (
    $past(output_action_a) == 2'h1 && $past(waveform_select) inside {4'h9, 4'hb} && $changed(compare_out_a)
    |-> $past(counter_value) == $past(compare_a_value))
    else $error("output a toggled without a match");
  chk_noninv_set: assert property (
    $past(output_action_a) == 2'h2 && $rose(compare_out_a)
    |-> $past(counter_value) == $past(compare_a_value) && counter_value < $past(counter_value))
    else $error("non-inverting output set off a down match");
  chk_pin_dir: assert property (!$past(reset) |-> pin_a_oe_n == !$past(pin_direction_bit_a))
    else $error("pin a enable does not follow direction");
  chk_port_pass: assert property (
    !$past(reset) && $past(output_action_a) == 2'h0 |-> pin_a_out == $past(port_data_a))
    else $error("disconnected pin a not port data");
  chk_stop_hold: assert property (prescale_select == 3'h0 |=> $stable(counter_value))
    else $error("counter moved while stopped");
endmodule : dspt_chk

bind dspt_timer dspt_chk u_chk (.clk_sys, .reset, .waveform_select, .prescale_select, .output_action_a,
  .pin_direction_bit_a, .port_data_a, .capture_top_wr, .wr_data, .counter_value, .compare_a_value,
  .compare_b_value, .capture_top_value, .flags, .compare_out_a, .pin_a_out, .pin_a_oe_n);

// ### tb/dspt_pin_model.sv
/*
  Port pin seen by the external load.
  Assumes drive and oe_n come from the timer's pin outputs.
*/
module dspt_pin_model (
  input  wire logic clk_sys,
  input  wire logic drive,
  input  wire logic oe_n,
  output logic      pad
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last = 1'b0;
  always @(posedge clk_sys) begin
    if (!oe_n) last <= drive;
  end
  // Released pad shows the inverse of its last level, never a stale copy
  assign pad = oe_n ? ~last : drive;
endmodule : dspt_pin_model

// ### tb/tb.sv
/*
  Self-checking bench for the dual-slope timer.
  Assumes the checker bind and the pin model are compiled with it.
*/
module tb
  import dspt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    int          id;
    logic [15:0] exp;
  } dspt_note_t;
  logic        clk_sys, reset, compare_a_wr, compare_b_wr, capture_top_wr;
  logic [3:0]  waveform_select;
  logic [2:0]  prescale_select;
  logic [1:0]  output_action_a, output_action_b;
  logic        pin_direction_bit_a, pin_direction_bit_b, port_data_a, port_data_b;
  logic [15:0] wr_data, counter_value, compare_a_value, compare_b_value, capture_top_value;
  dspt_flags_t flag_clear, flags;
  logic        compare_out_a, compare_out_b, pin_a_out, pin_a_oe_n, pin_b_out, pin_b_oe_n, pad_a, pad_b;
  logic [15:0] prev_cnt, seen, top;
  logic [31:0] seed = 32'h0000ed5d;
  int          miscompares, check_count, cyc, last_bottom, last_step, period_seen, gap_seen, hi_cnt, c;
  dspt_note_t  notes[$];
  dspt_note_t  n;
  string       what [9] = '{"counter", "compare_a", "capture_top", "flags", "outs", "pins", "period", "gap", "high"};

  dspt_timer DUT (.clk_sys, .reset, .waveform_select, .prescale_select, .output_action_a, .output_action_b,
    .pin_direction_bit_a, .pin_direction_bit_b, .port_data_a, .port_data_b, .compare_a_wr, .compare_b_wr,
    .capture_top_wr, .wr_data, .flag_clear, .counter_value, .compare_a_value, .compare_b_value,
    .capture_top_value, .flags, .compare_out_a, .compare_out_b, .pin_a_out, .pin_a_oe_n, .pin_b_out, .pin_b_oe_n);
  dspt_pin_model u_pad_a (.clk_sys, .drive(pin_a_out), .oe_n(pin_a_oe_n), .pad(pad_a));
  dspt_pin_model u_pad_b (.clk_sys, .drive(pin_b_out), .oe_n(pin_b_oe_n), .pad(pad_b));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Watches the counter: bottom-to-bottom period, tick gap, time output a is high
  always @(negedge clk_sys) begin
    {port_data_a, port_data_b} <= 2'(rnd());
    if (counter_value === 16'h0001 && prev_cnt === 16'h0000) begin
      period_seen = cyc - last_bottom;
      last_bottom = cyc;
    end
    if (counter_value !== prev_cnt) begin
      gap_seen = cyc - last_step;
      last_step = cyc;
    end
    if (compare_out_a === 1'b1) hi_cnt++;
    prev_cnt = counter_value;
    cyc++;
  end

  initial forever begin
    wait (notes.size() != 0);
    n = notes.pop_front();
    case (n.id)
      0: seen = counter_value;
      1: seen = compare_a_value;
      2: seen = capture_top_value;
      3: seen = 16'(flags);
      4: seen = {compare_b_value[13:0], compare_out_b, compare_out_a};
      5: seen = {13'h0000, pin_b_out, pin_b_oe_n, pad_a};
      6: seen = 16'(period_seen);
      7: seen = 16'(gap_seen);
      default: seen = 16'(hi_cnt);
    endcase
    check_count++;
    if (seen !== n.exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what[n.id], n.exp, seen);
    end
  end

  task automatic note(int id, logic [15:0] v);
    #0.1;
    notes.push_back('{id, v});
  endtask : note

  task automatic wr(int sel, logic [15:0] d);
    @(negedge clk_sys);
    wr_data = d;
    {compare_a_wr, compare_b_wr, capture_top_wr} = 3'(3'h4 >> sel);
    @(negedge clk_sys);
    {compare_a_wr, compare_b_wr, capture_top_wr} = 3'h0;
  endtask : wr

  // Waits for a counter value, or with chg set for any counter step
  task automatic wait_cnt(logic [15:0] v, bit chg);
    logic [15:0] s;
    int          k;
    s = counter_value;
    for (k = 0; k < 4000 && (chg ? counter_value === s : counter_value !== v); k++) @(negedge clk_sys);
    if (k == 4000) begin
      miscompares++;
      $display("MISMATCH wait counter expected %h seen %h", v, counter_value);
      end_of_test();
    end
  endtask : wait_cnt

  task end_of_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    reset = 1'b1;
    {waveform_select, prescale_select} = 7'h50;
    {output_action_a, output_action_b, pin_direction_bit_a, pin_direction_bit_b} = 6'h2e;
    {compare_a_wr, compare_b_wr, capture_top_wr} = 3'h0;
    wr_data = 16'h0000;
    flag_clear = 4'h0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    top = 16'h0003 + 16'(rnd() & 32'h0000_0003);
    wr(2, top);
    note(2, top);
    wr(0, 16'h0001);
    wr(1, 16'h0001);
    prescale_select = 3'h1;
    wait_cnt(16'h0001, 1'b0);
    for (int i = 1; i <= 2 * top; i++) begin
      @(negedge clk_sys);
      flag_clear = (i == 1) ? 4'hf : 4'h0;
      c = (i + 1) % (2 * top);
      note(0, 16'(c <= top ? c : 2 * top - c));
      if (c == top + 1) note(3, 16'h0004);
    end
    note(3, 16'h000f);
    note(4, 16'h0005);
    note(5, 16'h0003);
    for (int m = 1; m <= 3; m++) begin
      waveform_select = 4'(m);
      wr(0, 16'hffff);
      top = (16'h0080 << m) - 16'h0001;
      wait_cnt(top, 1'b0);
      @(negedge clk_sys);
      note(0, top - 16'h0001);
      note(1, top);
    end
    waveform_select = 4'h9;
    wr(0, 16'h0004);
    // The falling slope passes 1 first; the load only happens at BOTTOM
    wait_cnt(16'h0000, 1'b0);
    wait_cnt(16'h0001, 1'b0);
    note(1, 16'h0004);
    output_action_a = 2'h1;
    prescale_select = 3'h2;
    wait_cnt(16'h0000, 1'b0);
    wait_cnt(16'h0001, 1'b0);
    #0.1;
    hi_cnt = 0;
    repeat (2) begin
      wait_cnt(16'h0000, 1'b0);
      wait_cnt(16'h0001, 1'b0);
    end
    note(6, 16'h0040);
    note(8, 16'h0040);
    prescale_select = 3'h1;
    wr(2, 16'h0005);
    waveform_select = 4'h8;
    wait_cnt(16'h0005, 1'b0);
    @(negedge clk_sys);
    note(0, 16'h0004);
    output_action_a = 2'h0;
    for (int p = 3; p <= 5; p++) begin
      prescale_select = 3'(p);
      wait_cnt(16'h0000, 1'b1);
      wait_cnt(16'h0000, 1'b1);
      note(7, 16'(1 << (2 * p)));
    end
    #1;
    end_of_test();
  end
endmodule : tb
